// file: include/ccs_pkg.sv
// constants, field layouts and types of the clock source and pll configuration block
package ccs_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SWITCH_GUARD_NS = 100;
  localparam int unsigned SWITCH_GUARD_CYC = (SWITCH_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STRAP_SETTLE_CYC = 3;
  localparam logic [19:0] GATE_CYC_PER_UNIT = 20'h0000F;

  localparam logic [11:0] OFS_CLK_SEL = 12'h028;
  localparam logic [11:0] OFS_PLL_BW = 12'h02C;
  localparam logic [11:0] OFS_PLL1_MODE = 12'h030;
  localparam logic [11:0] OFS_PLL23 = 12'h034;
  localparam logic [11:0] OFS_AXI2_GATE = 12'h038;

  localparam logic [23:0] RST_CLK_SEL = 24'h015021;
  localparam logic [5:0] RST_PLL_BW = 6'h2A;
  localparam logic [4:0] RST_PLL3_M = 5'h03;
  localparam logic [6:0] RST_PLL3_N = 7'h36;
  localparam logic [1:0] RST_PLL3_RANGE = 2'h3;
  localparam logic RST_PLL_EN = 1'b1;
  localparam logic PLL_STABLE = 1'b1;

  localparam logic [1:0] GATE_MODE_RUN = 2'h0;
  localparam logic [1:0] GATE_MODE_PWM = 2'h1;

  typedef enum logic [4:0] {
    SRC_AXI, SRC_AHB, SRC_PLL0_DIV2, SRC_PLL1, SRC_PLL1_DIV2, SRC_PLL1_DIV3, SRC_PLL1_DIVOUT,
    SRC_PLL2, SRC_PLL2_DIVOUT, SRC_PLL3, SRC_PLL3_DIV2, SRC_EXT_REF, SRC_MAIN_OSC,
    SRC_LOW_OSC, SRC_ADDA_HALF, SRC_SCALER_DIV, SRC_PIXEL_DIV
  } ccs_src_e;

  typedef struct packed {
    logic pll3_out_half;
    logic [1:0] isp;
    logic denoise;
    logic rsvd19;
    logic ext_out_spread_select;
    logic codec;
    logic [1:0] adda;
    logic [1:0] ssp1;
    logic [1:0] ssp0;
    logic spi;
    logic scaler;
    logic panel;
    logic sdc;
    logic camphy;
    logic [1:0] rmii;
    logic uart;
    logic [1:0] ext;
    logic rtc;
  } ccs_clk_sel_s;

  typedef struct packed {
    logic [15:0] clock_mode;
    logic [4:0] first_pll_m_value;
    logic [6:0] first_pll_n_value;
    logic [1:0] first_pll_range;
    logic stable;
    logic first_pll_disable;
  } ccs_pll1_reg_s;

  typedef struct packed {
    logic [4:0] m3;
    logic [6:0] n3;
    logic [1:0] range3;
    logic stable3;
    logic third_pll_enable;
    logic [4:0] m2;
    logic [6:0] n2;
    logic [1:0] range2;
    logic stable2;
    logic second_pll_enable;
  } ccs_pll23_reg_s;

  typedef struct packed {
    logic [15:0] period;
    logic [12:0] rsvd;
    logic [1:0] mode;
    logic apply;
  } ccs_gate_reg_s;

  typedef struct packed {
    logic rsvd15;
    logic [2:0] ddr_dll_range;
    logic [1:0] rsvd11;
    logic [1:0] axi2_div;
    logic rsvd7;
    logic cpu_from_pll2;
    logic [1:0] axi_div;
    logic [1:0] ahb_div;
    logic [1:0] ddr_div;
  } ccs_cpu_mode_s;

  typedef struct packed {
    logic [15:0] clock_mode;
    logic [4:0] m1;
    logic [6:0] n1;
    logic [1:0] range1;
    logic [4:0] m2;
    logic [6:0] n2;
    logic [1:0] range2;
  } ccs_strap_s;

  typedef struct packed {
    logic [4:0] m;
    logic [6:0] n;
    logic [1:0] range;
    logic [1:0] bandwidth;
    logic enable;
  } ccs_pll_cfg_s;

  typedef struct packed {
    ccs_src_e pll3_out;
    ccs_src_e isp;
    ccs_src_e denoise;
    ccs_src_e codec;
    ccs_src_e adda;
    ccs_src_e ssp1;
    ccs_src_e ssp0;
    ccs_src_e spi;
    ccs_src_e scaler;
    ccs_src_e panel;
    ccs_src_e sdc;
    ccs_src_e camphy;
    ccs_src_e rmii;
    ccs_src_e uart;
    ccs_src_e ext;
    ccs_src_e rtc;
    logic ext_spread;
  } ccs_route_s;

  typedef enum logic [1:0] {SW_IDLE, SW_QUIET, SW_SETTLE} ccs_switch_e;

endpackage : ccs_pkg

// file: src/ccs_clock_config.sv
// clock source selection, pll configuration and secondary axi clock gating with apb access
// What this block does
// - third pll output select bit: 0 undivided, 1 divided by two
// - image processor select: 00 axi, 01 ahb, 1x pll1 divided by three
// - de-noise bit: ahb or axi; video codec bit: ahb or pll1 divided by three
// - external clock output bypasses spread spectrum at 0, passes through at 1
// - audio and both serial ports: 00 pll3, 01 pll1 divided, 1x pll2; reset 2
// - serial flash clock bit: 0 pll2, 1 pll1 divided output
// - scaler bit: pll3 divider or pixel divider; panel bit: pll3 or pll2
// - sd card clock bit: 0 pll2, 1 pll1
// - camera phy clock bit: 0 pll3 halved, 1 pll1 halved
// - ethernet rmii select: 00 pll2, 01 reference pin, 1x pll1; reset 2
// - uart clock bit: 0 pll0 halved, 1 pll1 halved
// - external clock source: 00 pll3, 01 main oscillator, 1x pll2 divided
// - real-time clock bit: 0 low-speed oscillator, 1 audio clock halved; reset 1
// - each pll has a 2-bit bandwidth option, reset to 2
// - clock mode field picks bus and ddr dividers and cpu pll; reset from straps
// - mode bits 14 to 12 carry the ddr dll frequency range
// - each pll takes 5-bit m and 7-bit n; pll3 resets 3 and 0x36
// - each pll has a 2-bit output range field
// - pll1 disabled by 1, pll2 and pll3 enabled by 1; stable flags read 1
// - gating mode: 0 running, 1 periodic gating, 2 or 3 held off
// - writing 1 to apply loads mode and period; the apply bit self-clears
//
// Chosen here: the APB interface to the registers.
module ccs_clock_config (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ccs_pkg::ccs_strap_s strap_pins,
  output ccs_pkg::ccs_route_s clk_route,
  output logic [16:0] clk_route_en,
  output ccs_pkg::ccs_pll_cfg_s pll1_cfg,
  output ccs_pkg::ccs_pll_cfg_s pll2_cfg,
  output ccs_pkg::ccs_pll_cfg_s pll3_cfg,
  output ccs_pkg::ccs_cpu_mode_s cpu_mode,
  output ccs_pkg::ccs_src_e cpu_src,
  output logic axi2_clk_en
);

  // three-way selector shared by the audio and serial port fields
  function automatic ccs_pkg::ccs_src_e sel_three(input logic [1:0] code);
    if (code == 2'h0) begin
      sel_three = ccs_pkg::SRC_PLL3;
    end else if (code == 2'h1) begin
      sel_three = ccs_pkg::SRC_PLL1_DIVOUT;
    end else begin
      sel_three = ccs_pkg::SRC_PLL2;
    end
  endfunction : sel_three

  function automatic ccs_pkg::ccs_route_s decode_route(input ccs_pkg::ccs_clk_sel_s s);
    ccs_pkg::ccs_route_s r;
    r = '0;
    r.pll3_out = s.pll3_out_half ? ccs_pkg::SRC_PLL3_DIV2 : ccs_pkg::SRC_PLL3;
    r.isp = s.isp[1] ? ccs_pkg::SRC_PLL1_DIV3 :
      (s.isp[0] ? ccs_pkg::SRC_AHB : ccs_pkg::SRC_AXI);
    r.denoise = s.denoise ? ccs_pkg::SRC_AXI : ccs_pkg::SRC_AHB;
    r.codec = s.codec ? ccs_pkg::SRC_PLL1_DIV3 : ccs_pkg::SRC_AHB;
    r.ext_spread = s.ext_out_spread_select;
    r.adda = sel_three(s.adda);
    r.ssp1 = sel_three(s.ssp1);
    r.ssp0 = sel_three(s.ssp0);
    r.spi = s.spi ? ccs_pkg::SRC_PLL1_DIVOUT : ccs_pkg::SRC_PLL2;
    r.scaler = s.scaler ? ccs_pkg::SRC_PIXEL_DIV : ccs_pkg::SRC_SCALER_DIV;
    r.panel = s.panel ? ccs_pkg::SRC_PLL2 : ccs_pkg::SRC_PLL3;
    r.sdc = s.sdc ? ccs_pkg::SRC_PLL1 : ccs_pkg::SRC_PLL2;
    r.camphy = s.camphy ? ccs_pkg::SRC_PLL1_DIV2 : ccs_pkg::SRC_PLL3_DIV2;
    r.rmii = s.rmii[1] ? ccs_pkg::SRC_PLL1 :
      (s.rmii[0] ? ccs_pkg::SRC_EXT_REF : ccs_pkg::SRC_PLL2);
    r.uart = s.uart ? ccs_pkg::SRC_PLL1_DIV2 : ccs_pkg::SRC_PLL0_DIV2;
    r.ext = s.ext[1] ? ccs_pkg::SRC_PLL2_DIVOUT :
      (s.ext[0] ? ccs_pkg::SRC_MAIN_OSC : ccs_pkg::SRC_PLL3);
    r.rtc = s.rtc ? ccs_pkg::SRC_ADDA_HALF : ccs_pkg::SRC_LOW_OSC;
    decode_route = r;
  endfunction : decode_route

  // one bit per routed consumer, same order as the route struct
  function automatic logic [16:0] route_diff(input ccs_pkg::ccs_route_s a,
      input ccs_pkg::ccs_route_s b);
    route_diff = {a.pll3_out != b.pll3_out, a.isp != b.isp, a.denoise != b.denoise,
      a.codec != b.codec, a.adda != b.adda, a.ssp1 != b.ssp1, a.ssp0 != b.ssp0,
      a.spi != b.spi, a.scaler != b.scaler, a.panel != b.panel, a.sdc != b.sdc,
      a.camphy != b.camphy, a.rmii != b.rmii, a.uart != b.uart, a.ext != b.ext,
      a.rtc != b.rtc, a.ext_spread != b.ext_spread};
  endfunction : route_diff

  // strap capture
  ccs_pkg::ccs_strap_s strap_meta_ff;
  ccs_pkg::ccs_strap_s strap_sync_ff;
  logic [1:0] strap_cnt_ff;
  logic strap_done_ff;
  logic strap_load;

  // registers
  ccs_pkg::ccs_clk_sel_s sel_ff;
  logic [5:0] bw_ff;
  ccs_pkg::ccs_pll1_reg_s pll1_ff;
  ccs_pkg::ccs_pll23_reg_s pll23_ff;
  ccs_pkg::ccs_gate_reg_s gate_ff;
  logic [31:0] prdata_ff;

  // apb decode
  wire logic setup_phase = psel & ~penable;
  wire logic access_phase = psel & penable & strap_done_ff;
  wire logic hit_sel = (paddr == ccs_pkg::OFS_CLK_SEL);
  wire logic hit_bw = (paddr == ccs_pkg::OFS_PLL_BW);
  wire logic hit_pll1 = (paddr == ccs_pkg::OFS_PLL1_MODE);
  wire logic hit_pll23 = (paddr == ccs_pkg::OFS_PLL23);
  wire logic hit_gate = (paddr == ccs_pkg::OFS_AXI2_GATE);
  wire logic hit_any = hit_sel | hit_bw | hit_pll1 | hit_pll23 | hit_gate;
  wire logic wr_en = access_phase & pwrite & hit_any;
  wire logic wr_sel = wr_en & hit_sel;
  wire logic wr_bw = wr_en & hit_bw;
  wire logic wr_pll1 = wr_en & hit_pll1;
  wire logic wr_pll23 = wr_en & hit_pll23;
  wire logic wr_gate = wr_en & hit_gate;

  // stable flags are not storage; they always read as one
  ccs_pkg::ccs_pll1_reg_s pll1_view;
  ccs_pkg::ccs_pll23_reg_s pll23_view;
  ccs_pkg::ccs_gate_reg_s gate_view;
  always_comb begin
    pll1_view = pll1_ff;
    pll1_view.stable = ccs_pkg::PLL_STABLE;
    pll23_view = pll23_ff;
    pll23_view.stable3 = ccs_pkg::PLL_STABLE;
    pll23_view.stable2 = ccs_pkg::PLL_STABLE;
    gate_view = gate_ff;
    gate_view.rsvd = '0;
  end

  logic [31:0] rd_value;
  always_comb begin
    if (hit_sel) begin
      rd_value = {8'h00, sel_ff[23:20], 1'b0, sel_ff[18:0]};
    end else if (hit_bw) begin
      rd_value = {26'h0000000, bw_ff};
    end else if (hit_pll1) begin
      rd_value = pll1_view;
    end else if (hit_pll23) begin
      rd_value = pll23_view;
    end else if (hit_gate) begin
      rd_value = gate_view;
    end else begin
      rd_value = 32'h00000000;
    end
  end

  assign pready = strap_done_ff;
  assign pslverr = access_phase & ~hit_any;
  assign prdata = prdata_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_ff <= 32'h00000000;
    end else if (setup_phase) begin
      prdata_ff <= pwrite ? 32'h00000000 : rd_value;
    end
  end

  // straps: two-stage sync, then loaded once after reset release
  assign strap_load = ~strap_done_ff &
    (strap_cnt_ff == 2'(ccs_pkg::STRAP_SETTLE_CYC - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_meta_ff <= '0;
      strap_sync_ff <= '0;
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
    end else begin
      strap_meta_ff <= strap_pins;
      strap_sync_ff <= strap_meta_ff;
      if (!strap_done_ff) begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      end
      if (strap_load) begin
        strap_done_ff <= 1'b1;
      end
    end
  end

  // select and bandwidth registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_ff <= ccs_pkg::RST_CLK_SEL;
      bw_ff <= ccs_pkg::RST_PLL_BW;
    end else begin
      if (wr_sel) begin
        sel_ff <= pwdata[23:0];
      end
      if (wr_bw) begin
        bw_ff <= pwdata[5:0];
      end
    end
  end

  // pll control registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pll1_ff <= '0;
      pll23_ff <= '0;
      pll23_ff.m3 <= ccs_pkg::RST_PLL3_M;
      pll23_ff.n3 <= ccs_pkg::RST_PLL3_N;
      pll23_ff.range3 <= ccs_pkg::RST_PLL3_RANGE;
      pll23_ff.third_pll_enable <= ccs_pkg::RST_PLL_EN;
      pll23_ff.second_pll_enable <= ccs_pkg::RST_PLL_EN;
    end else if (strap_load) begin
      pll1_ff.clock_mode <= strap_sync_ff.clock_mode;
      pll1_ff.first_pll_m_value <= strap_sync_ff.m1;
      pll1_ff.first_pll_n_value <= strap_sync_ff.n1;
      pll1_ff.first_pll_range <= strap_sync_ff.range1;
      pll23_ff.m2 <= strap_sync_ff.m2;
      pll23_ff.n2 <= strap_sync_ff.n2;
      pll23_ff.range2 <= strap_sync_ff.range2;
    end else begin
      if (wr_pll1) begin
        pll1_ff <= pwdata;
      end
      if (wr_pll23) begin
        pll23_ff <= pwdata;
      end
    end
  end

  assign cpu_mode = pll1_ff.clock_mode;
  assign cpu_src = pll1_ff.clock_mode[6] ? ccs_pkg::SRC_PLL2 : ccs_pkg::SRC_PLL1;

  always_comb begin
    pll1_cfg.m = pll1_ff.first_pll_m_value;
    pll1_cfg.n = pll1_ff.first_pll_n_value;
    pll1_cfg.range = pll1_ff.first_pll_range;
    pll1_cfg.bandwidth = bw_ff[1:0];
    pll1_cfg.enable = ~pll1_ff.first_pll_disable;
    pll2_cfg.m = pll23_ff.m2;
    pll2_cfg.n = pll23_ff.n2;
    pll2_cfg.range = pll23_ff.range2;
    pll2_cfg.bandwidth = bw_ff[3:2];
    pll2_cfg.enable = pll23_ff.second_pll_enable;
    pll3_cfg.m = pll23_ff.m3;
    pll3_cfg.n = pll23_ff.n3;
    pll3_cfg.range = pll23_ff.range3;
    pll3_cfg.bandwidth = bw_ff[5:4];
    pll3_cfg.enable = pll23_ff.third_pll_enable;
  end

  // secondary axi clock gating
  logic [1:0] act_mode_ff;
  logic [15:0] act_period_ff;
  logic [19:0] gate_cnt_ff;
  logic axi2_en_ff;
  logic [19:0] off_len;
  logic [19:0] nxt_gate_cnt;
  logic nxt_axi2_en;

  assign off_len = 20'(act_period_ff) * ccs_pkg::GATE_CYC_PER_UNIT;

  always_comb begin
    nxt_gate_cnt = gate_cnt_ff;
    nxt_axi2_en = 1'b0;
    if (act_mode_ff == ccs_pkg::GATE_MODE_RUN) begin
      nxt_axi2_en = 1'b1;
    end else if (act_mode_ff == ccs_pkg::GATE_MODE_PWM) begin
      if (gate_cnt_ff == 20'h00000) begin
        nxt_axi2_en = 1'b1;
        nxt_gate_cnt = off_len;
      end else begin
        nxt_gate_cnt = gate_cnt_ff - 20'h00001;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_ff <= '0;
      act_mode_ff <= ccs_pkg::GATE_MODE_RUN;
      act_period_ff <= 16'h0000;
      gate_cnt_ff <= 20'h00000;
      axi2_en_ff <= 1'b1;
    end else begin
      if (wr_gate) begin
        gate_ff <= pwdata;
      end else if (gate_ff.apply) begin
        gate_ff.apply <= 1'b0;
      end
      if (gate_ff.apply) begin
        act_mode_ff <= gate_ff.mode;
        act_period_ff <= gate_ff.period;
        gate_cnt_ff <= 20'h00000;
      end else begin
        gate_cnt_ff <= nxt_gate_cnt;
      end
      axi2_en_ff <= nxt_axi2_en;
    end
  end

  assign axi2_clk_en = axi2_en_ff;

  // glitch-free switching of the routed sources
  ccs_pkg::ccs_switch_e sw_state_ff;
  ccs_pkg::ccs_switch_e nxt_sw_state;
  ccs_pkg::ccs_route_s applied_ff;
  ccs_pkg::ccs_route_s target_route;
  logic [16:0] quiet_ff;
  logic [16:0] nxt_quiet;
  logic [2:0] guard_ff;
  logic [2:0] nxt_guard;
  logic apply_route;
  logic [16:0] diff;

  assign target_route = decode_route(sel_ff);
  assign diff = route_diff(target_route, applied_ff);

  always_comb begin
    nxt_sw_state = sw_state_ff;
    nxt_quiet = quiet_ff;
    nxt_guard = guard_ff;
    apply_route = 1'b0;
    case (sw_state_ff)
      ccs_pkg::SW_IDLE: begin
        if (diff != 17'h00000) begin
          nxt_quiet = diff;
          nxt_guard = 3'(ccs_pkg::SWITCH_GUARD_CYC - 1);
          nxt_sw_state = ccs_pkg::SW_QUIET;
        end
      end
      ccs_pkg::SW_QUIET: begin
        nxt_quiet = quiet_ff | diff;
        if ((diff & ~quiet_ff) != 17'h00000) begin
          nxt_guard = 3'(ccs_pkg::SWITCH_GUARD_CYC - 1);
        end else if (guard_ff == 3'h0) begin
          apply_route = 1'b1;
          nxt_guard = 3'(ccs_pkg::SWITCH_GUARD_CYC - 1);
          nxt_sw_state = ccs_pkg::SW_SETTLE;
        end else begin
          nxt_guard = guard_ff - 3'h1;
        end
      end
      ccs_pkg::SW_SETTLE: begin
        if (guard_ff == 3'h0) begin
          nxt_quiet = 17'h00000;
          nxt_sw_state = ccs_pkg::SW_IDLE;
        end else begin
          nxt_guard = guard_ff - 3'h1;
        end
      end
      default: begin
        nxt_sw_state = ccs_pkg::SW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_state_ff <= ccs_pkg::SW_IDLE;
      quiet_ff <= 17'h00000;
      guard_ff <= 3'h0;
      applied_ff <= decode_route(ccs_pkg::RST_CLK_SEL);
    end else begin
      sw_state_ff <= nxt_sw_state;
      quiet_ff <= nxt_quiet;
      guard_ff <= nxt_guard;
      if (apply_route) begin
        applied_ff <= target_route;
      end
    end
  end

  assign clk_route = applied_ff;
  assign clk_route_en = ~quiet_ff;

endmodule : ccs_clock_config

// file: test/ccs_far_model.sv
// far side: strap levels and a consumer timing gated stretches of the secondary axi clock
module ccs_far_model #(
  parameter ccs_pkg::ccs_strap_s STRAP = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic axi2_clk_en,
  output ccs_pkg::ccs_strap_s strap_pins,
  output logic [19:0] last_gap_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] gap_ff;
  // straps are static pin levels
  assign strap_pins = STRAP;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_ff <= 20'h00000;
      last_gap_ff <= 20'h00000;
    end else if (!axi2_clk_en) begin
      gap_ff <= gap_ff + 20'h00001;
    end else begin
      if (gap_ff != 20'h00000) begin
        last_gap_ff <= gap_ff;
      end
      gap_ff <= 20'h00000;
    end
  end
endmodule : ccs_far_model

// file: test/ccs_clock_config_properties.sv
// concurrent checks on the ports of the clock configuration block
module ccs_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire ccs_pkg::ccs_route_s clk_route,
  input wire logic [16:0] clk_route_en,
  input wire ccs_pkg::ccs_pll_cfg_s pll3_cfg,
  input wire ccs_pkg::ccs_cpu_mode_s cpu_mode,
  input wire ccs_pkg::ccs_src_e cpu_src,
  input wire logic axi2_clk_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic gate_wr;
  assign gate_wr = psel && penable && pready && pwrite && pwdata[0]
    && paddr == ccs_pkg::OFS_AXI2_GATE;
  property p_strap_wait;
    $rose(reset_n) |-> !pready ##[2:4] pready;
  endproperty
  a_strap_wait: assert property (p_strap_wait) else $error("strap load timing wrong");
  property p_pll3_reset;
    $rose(reset_n) |-> pll3_cfg.m == 5'h03 && pll3_cfg.n == 7'h36 && pll3_cfg.enable;
  endproperty
  a_pll3_reset: assert property (p_pll3_reset) else $error("pll3 reset setting wrong");
  // mode bit 6 sits at bus bit 22; checks the register path, not only the mux
  property p_cpu_src;
    psel && penable && pready && pwrite && paddr == ccs_pkg::OFS_PLL1_MODE
      |=> cpu_src == ($past(pwdata[22]) ? ccs_pkg::SRC_PLL2 : ccs_pkg::SRC_PLL1);
  endproperty
  a_cpu_src: assert property (p_cpu_src) else $error("cpu source mismatch");
  property p_gate_off;
    gate_wr && pwdata[2] |-> ##4 (!axi2_clk_en) [*4];
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gated clock not held off");
  property p_gate_run;
    gate_wr && pwdata[2:1] == 2'h0 |-> ##4 axi2_clk_en [*4];
  endproperty
  a_gate_run: assert property (p_gate_run) else $error("gated clock not running");
  property p_break_first;
    $changed(clk_route.adda) |-> !clk_route_en[12] && !$past(clk_route_en[12]);
  endproperty
  a_break_first: assert property (p_break_first) else $error("route switched while on");
  property p_en_back;
    $fell(clk_route_en[12]) |-> ##[1:20] clk_route_en[12];
  endproperty
  a_en_back: assert property (p_en_back) else $error("route enable not restored");
  property p_adda_codes;
    clk_route.adda inside {ccs_pkg::SRC_PLL3, ccs_pkg::SRC_PLL1_DIVOUT, ccs_pkg::SRC_PLL2};
  endproperty
  a_adda_codes: assert property (p_adda_codes) else $error("audio route illegal");
  property p_rtc_codes;
    clk_route.rtc inside {ccs_pkg::SRC_LOW_OSC, ccs_pkg::SRC_ADDA_HALF};
  endproperty
  a_rtc_codes: assert property (p_rtc_codes) else $error("rtc route illegal");
  c_gate_wr: cover property (gate_wr);
  c_switch: cover property ($fell(clk_route_en[12]));
  c_cpu_pll2: cover property (cpu_mode.cpu_from_pll2);
endmodule : ccs_props

bind ccs_clock_config ccs_props i_props (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .clk_route(clk_route),
  .clk_route_en(clk_route_en), .pll3_cfg(pll3_cfg), .cpu_mode(cpu_mode),
  .cpu_src(cpu_src), .axi2_clk_en(axi2_clk_en)
);

// file: test/tb.sv
// self-checking bench: apb register traffic against the clock configuration block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam ccs_pkg::ccs_strap_s STRAP = '{clock_mode:16'h2145, m1:5'h05, n1:7'h2A,
    range1:2'h2, m2:5'h06, n2:7'h31, range2:2'h1};
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, axi2_clk_en, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [16:0] clk_route_en;
  logic [19:0] gap;
  ccs_pkg::ccs_strap_s strap_pins;
  ccs_pkg::ccs_route_s clk_route;
  ccs_pkg::ccs_pll_cfg_s pll1_cfg, pll2_cfg, pll3_cfg;
  ccs_pkg::ccs_cpu_mode_s cpu_mode;
  ccs_pkg::ccs_src_e cpu_src;
  int n_fail = 0;
  int check_count = 0;
  logic [23:0] sel_tab [5] = '{24'h000000, 24'h20A812, 24'h415024, 24'hF7FFFF, 24'h015021};

  ccs_clock_config i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strap_pins(strap_pins), .clk_route(clk_route),
    .clk_route_en(clk_route_en), .pll1_cfg(pll1_cfg), .pll2_cfg(pll2_cfg),
    .pll3_cfg(pll3_cfg), .cpu_mode(cpu_mode), .cpu_src(cpu_src), .axi2_clk_en(axi2_clk_en));
  ccs_far_model #(.STRAP(STRAP)) i_far (.clk(clk), .reset_n(reset_n),
    .axi2_clk_en(axi2_clk_en), .strap_pins(strap_pins), .last_gap_ff(gap));

  task automatic stop_test();
    if (n_fail == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      n_fail++;
      stop_test();
    end else begin
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rdat, exp);
  endtask : rd

  task automatic settle();
    int n;
    repeat (3) @(posedge clk);
    n = 0;
    while (clk_route_en !== 17'h1FFFF && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      n_fail++;
      stop_test();
    end
  endtask : settle

  function automatic ccs_pkg::ccs_src_e pick3(input logic [1:0] c);
    return c[1] ? ccs_pkg::SRC_PLL2 : (c[0] ? ccs_pkg::SRC_PLL1_DIVOUT : ccs_pkg::SRC_PLL3);
  endfunction : pick3

  function automatic ccs_pkg::ccs_route_s exp_route(input logic [23:0] s);
    ccs_pkg::ccs_route_s r;
    r.pll3_out = s[23] ? ccs_pkg::SRC_PLL3_DIV2 : ccs_pkg::SRC_PLL3;
    r.isp = s[22] ? ccs_pkg::SRC_PLL1_DIV3 : (s[21] ? ccs_pkg::SRC_AHB : ccs_pkg::SRC_AXI);
    r.denoise = s[20] ? ccs_pkg::SRC_AXI : ccs_pkg::SRC_AHB;
    r.ext_spread = s[18];
    r.codec = s[17] ? ccs_pkg::SRC_PLL1_DIV3 : ccs_pkg::SRC_AHB;
    r.adda = pick3(s[16:15]);
    r.ssp1 = pick3(s[14:13]);
    r.ssp0 = pick3(s[12:11]);
    r.spi = s[10] ? ccs_pkg::SRC_PLL1_DIVOUT : ccs_pkg::SRC_PLL2;
    r.scaler = s[9] ? ccs_pkg::SRC_PIXEL_DIV : ccs_pkg::SRC_SCALER_DIV;
    r.panel = s[8] ? ccs_pkg::SRC_PLL2 : ccs_pkg::SRC_PLL3;
    r.sdc = s[7] ? ccs_pkg::SRC_PLL1 : ccs_pkg::SRC_PLL2;
    r.camphy = s[6] ? ccs_pkg::SRC_PLL1_DIV2 : ccs_pkg::SRC_PLL3_DIV2;
    r.rmii = s[5] ? ccs_pkg::SRC_PLL1 : (s[4] ? ccs_pkg::SRC_EXT_REF : ccs_pkg::SRC_PLL2);
    r.uart = s[3] ? ccs_pkg::SRC_PLL1_DIV2 : ccs_pkg::SRC_PLL0_DIV2;
    r.ext = s[2] ? ccs_pkg::SRC_PLL2_DIVOUT : (s[1] ? ccs_pkg::SRC_MAIN_OSC : ccs_pkg::SRC_PLL3);
    r.rtc = s[0] ? ccs_pkg::SRC_ADDA_HALF : ccs_pkg::SRC_LOW_OSC;
    return r;
  endfunction : exp_route

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rd(ccs_pkg::OFS_CLK_SEL, 32'h00015021);
    rd(ccs_pkg::OFS_PLL_BW, 32'h0000002A);
    rd(ccs_pkg::OFS_PLL1_MODE, {STRAP.clock_mode, STRAP.m1, STRAP.n1, STRAP.range1, 2'h2});
    rd(ccs_pkg::OFS_PLL23, {16'h1B6F, STRAP.m2, STRAP.n2, STRAP.range2, 2'h3});
    rd(ccs_pkg::OFS_AXI2_GATE, 32'h00000000);
    chk(clk_route, exp_route(24'h015021));
    chk(pll1_cfg.enable, 1'b1);
    foreach (sel_tab[i]) begin
      apb(1'b1, ccs_pkg::OFS_CLK_SEL, {8'hFF, sel_tab[i]});
      settle();
      chk(clk_route, exp_route(sel_tab[i]));
      rd(ccs_pkg::OFS_CLK_SEL, {8'h00, sel_tab[i]});
    end
    apb(1'b1, ccs_pkg::OFS_PLL_BW, 32'hFFFFFF1B);
    rd(ccs_pkg::OFS_PLL_BW, 32'h0000001B);
    chk({pll3_cfg.bandwidth, pll2_cfg.bandwidth, pll1_cfg.bandwidth}, 6'h1B);
    apb(1'b1, ccs_pkg::OFS_PLL_BW, 32'h00000024);
    repeat (2) @(posedge clk);
    chk({pll3_cfg.bandwidth, pll2_cfg.bandwidth, pll1_cfg.bandwidth}, 6'h24);
    apb(1'b1, ccs_pkg::OFS_PLL1_MODE, {16'h7040, 5'h1F, 7'h7F, 2'h0, 2'h1});
    rd(ccs_pkg::OFS_PLL1_MODE, {16'h7040, 5'h1F, 7'h7F, 2'h0, 2'h3});
    chk(cpu_src, ccs_pkg::SRC_PLL2);
    chk(cpu_mode.ddr_dll_range, 3'h7);
    chk(pll1_cfg, {5'h1F, 7'h7F, 2'h0, 2'h0, 1'b0});
    apb(1'b1, ccs_pkg::OFS_PLL1_MODE, 32'h00000000);
    repeat (2) @(posedge clk);
    chk({cpu_src, pll1_cfg.enable}, {ccs_pkg::SRC_PLL1, 1'b1});
    apb(1'b1, ccs_pkg::OFS_PLL23, {5'h0A, 7'h11, 2'h1, 2'h0, 5'h02, 7'h22, 2'h0, 2'h1});
    rd(ccs_pkg::OFS_PLL23, {5'h0A, 7'h11, 2'h1, 2'h2, 5'h02, 7'h22, 2'h0, 2'h3});
    chk(pll3_cfg, {5'h0A, 7'h11, 2'h1, 2'h2, 1'b0});
    chk(pll2_cfg, {5'h02, 7'h22, 2'h0, 2'h1, 1'b1});
    apb(1'b0, 12'h03C, 32'h00000000);
    chk({rerr, rdat}, {1'b1, 32'h00000000});
    for (int p = 1; p <= 2; p++) begin
      apb(1'b1, ccs_pkg::OFS_AXI2_GATE, {16'(p), 16'h0003});
      rd(ccs_pkg::OFS_AXI2_GATE, {16'(p), 16'h0002});
      repeat (80) @(posedge clk);
      chk(gap, 15 * p);
    end
    for (int m = 5; m <= 7; m += 2) begin
      apb(1'b1, ccs_pkg::OFS_AXI2_GATE, 32'(m));
      repeat (6) @(posedge clk);
      chk(axi2_clk_en, 1'b0);
    end
    apb(1'b1, ccs_pkg::OFS_AXI2_GATE, 32'h00000000);
    repeat (6) @(posedge clk);
    chk(axi2_clk_en, 1'b0);
    apb(1'b1, ccs_pkg::OFS_AXI2_GATE, 32'h00000001);
    repeat (6) @(posedge clk);
    chk(axi2_clk_en, 1'b1);
    stop_test();
  end
endmodule : tb
